// File: hdl/obl_params.svh
`ifndef OBL_PARAMS_SVH
`define OBL_PARAMS_SVH
// flash byte addresses of the option area
`define OBL_FLASH_PRI_BASE 16'h0080
`define OBL_FLASH_ALT_BASE 16'h1080
`define OBL_OPT_COUNT      3'h5
`define OBL_OPT_LAST       3'h4
// axi register byte offsets
`define OBL_REG_OSC_OPT    8'h80
`define OBL_REG_RSV_A      8'h81
`define OBL_REG_RSV_B      8'h82
`define OBL_REG_RSV_C      8'h83
`define OBL_REG_DBG_OPT    8'h84
`define OBL_REG_CTRL       8'h00
`define OBL_REG_STATUS     8'h04
// field positions
`define OBL_OSC_LOCK_BIT   0
`define OBL_CTRL_STOP_BIT  0
`define OBL_ST_DONE_BIT    0
`define OBL_ST_OSC_BIT     1
`define OBL_ST_DBGEN_BIT   2
`define OBL_ST_ERASE_BIT   3
`define OBL_ST_BAD_BIT     4
`define OBL_ST_SWAP_BIT    5
// debug control encodings
`define OBL_DBG_OFF        2'h0
`define OBL_DBG_BAD        2'h1
`define OBL_DBG_KEEP       2'h2
`define OBL_DBG_ERASE      2'h3
// axi responses
`define OBL_RESP_OKAY      2'h0
`define OBL_RESP_SLVERR    2'h2
`endif

// File: hdl/obl_pkg.sv
package obl_pkg;
  typedef enum logic [1:0] {
    obl_idle_s,
    obl_fetch_s,
    obl_wait_s,
    obl_done_s
  } obl_phase_t;

  typedef struct packed {
    obl_phase_t  phase;
    logic [2:0]  idx;
    logic        rd_req;
    logic [15:0] rd_addr;
    logic [7:0]  osc_opt;
    logic [7:0]  rsv_a;
    logic [7:0]  rsv_b;
    logic [7:0]  rsv_c;
    logic [7:0]  dbg_opt;
    logic        swapped;
    logic        stop_req;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } obl_state_t;
endpackage

// File: hdl/obl_option_byte_loader.sv
`timescale 1ns/1ps
`include "obl_params.svh"
// Contract
// - after every reset release, read flash option bytes 0080H-0084H
// - under boot swap, read 1080H-1084H instead
// - lock bit 0: software stop request stops internal oscillator
// - lock bit 1: oscillator keeps running, stop request ignored
// - lock bit 0: watchdog clock gated in halt and stop
// - timer h1 on internal oscillator keeps clock in halt/stop
// - debug field 00 disables debug; 01 is prohibited
// - debug field 10 enables debug, no erase on auth failure
// - debug field 11 enables debug, erase on auth failure
// - option bytes sampled during reset processing, before execution
module obl_option_byte_loader (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        boot_swap,
  output logic             flash_rd_req,
  output logic [15:0]      flash_rd_addr,
  input  wire logic        flash_rd_valid,
  input  wire logic [7:0]  flash_rd_data,
  output logic             cpu_release,
  output logic             internal_osc_run,
  input  wire logic        halt_or_stop,
  input  wire logic        h1_on_internal_osc,
  output logic             wdt_clk_enable,
  output logic             h1_clk_enable,
  output logic             debug_enable,
  output logic             debug_erase_on_fail,
  output logic             debug_setting_bad,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // =========================================================
  // state and decoded settings
  obl_pkg::obl_state_t r;
  obl_pkg::obl_state_t next_r;

  logic       lock;
  logic [1:0] dbg;
  logic       done;

  // =========================================================
  // decode helpers
  // debug field decode, shared by outputs and status
  function automatic logic obl_dbg_on(input logic [1:0] f);
    obl_dbg_on = (f == `OBL_DBG_KEEP) || (f == `OBL_DBG_ERASE);
  endfunction

  function automatic logic obl_dbg_wipe(input logic [1:0] f);
    obl_dbg_wipe = (f == `OBL_DBG_ERASE);
  endfunction

  function automatic logic obl_dbg_bad(input logic [1:0] f);
    obl_dbg_bad = (f == `OBL_DBG_BAD);
  endfunction

  // write byte lanes map to whole words; reads decode offsets 0x81..0x83 as their own registers
  function automatic logic [7:0] obl_word_addr(input logic [7:0] a);
    obl_word_addr = {a[7:2], 2'b00};
  endfunction

  function automatic logic [31:0] obl_read(input obl_pkg::obl_state_t s,
                                           input logic [7:0] a,
                                           output logic ok);
    obl_read = 32'h0000_0000;
    ok = 1'b1;
    case (a)
      `OBL_REG_OSC_OPT: obl_read = {24'h00_0000, s.osc_opt};
      `OBL_REG_RSV_A:   obl_read = {24'h00_0000, s.rsv_a};
      `OBL_REG_RSV_B:   obl_read = {24'h00_0000, s.rsv_b};
      `OBL_REG_RSV_C:   obl_read = {24'h00_0000, s.rsv_c};
      `OBL_REG_DBG_OPT: obl_read = {24'h00_0000, s.dbg_opt};
      `OBL_REG_CTRL:    obl_read = {31'h0000_0000, s.stop_req};
      `OBL_REG_STATUS: begin
        obl_read[`OBL_ST_DONE_BIT]  = (s.phase == obl_pkg::obl_done_s);
        obl_read[`OBL_ST_OSC_BIT]   = internal_osc_run;
        obl_read[`OBL_ST_DBGEN_BIT] = debug_enable;
        obl_read[`OBL_ST_ERASE_BIT] = debug_erase_on_fail;
        obl_read[`OBL_ST_BAD_BIT]   = debug_setting_bad;
        obl_read[`OBL_ST_SWAP_BIT]  = s.swapped;
      end
      default: ok = 1'b0;
    endcase
  endfunction

  assign lock = r.osc_opt[`OBL_OSC_LOCK_BIT];
  assign dbg  = r.dbg_opt[1:0];
  assign done = (r.phase == obl_pkg::obl_done_s);

  // =========================================================
  // next state
  always_comb begin
    logic        rd_ok;
    logic [31:0] rd_word;
    logic [7:0]  ra;
    rd_ok   = 1'b0;
    rd_word = 32'h0000_0000;
    ra      = 8'h00;
    next_r  = r;
    case (r.phase)
      obl_pkg::obl_idle_s: begin
        next_r.phase   = obl_pkg::obl_fetch_s;
        next_r.idx     = 3'h0;
        next_r.swapped = boot_swap;
        next_r.rd_addr = boot_swap ? `OBL_FLASH_ALT_BASE
                                   : `OBL_FLASH_PRI_BASE;
      end
      obl_pkg::obl_fetch_s: begin
        next_r.rd_req = 1'b1;
        next_r.phase  = obl_pkg::obl_wait_s;
      end
      obl_pkg::obl_wait_s: begin
        if (flash_rd_valid) begin
          next_r.rd_req = 1'b0;
          case (r.idx)
            3'h0:    next_r.osc_opt = flash_rd_data;
            3'h1:    next_r.rsv_a   = flash_rd_data;
            3'h2:    next_r.rsv_b   = flash_rd_data;
            3'h3:    next_r.rsv_c   = flash_rd_data;
            default: next_r.dbg_opt = flash_rd_data;
          endcase
          if (r.idx == `OBL_OPT_LAST) begin
            next_r.phase = obl_pkg::obl_done_s;
          end else begin
            next_r.idx     = r.idx + 3'h1;
            next_r.rd_addr = r.rd_addr + 16'h0001;
            next_r.phase   = obl_pkg::obl_fetch_s;
          end
        end
      end
      obl_pkg::obl_done_s: next_r.phase = obl_pkg::obl_done_s;
      default: next_r.phase = obl_pkg::obl_idle_s;
    endcase

    // axi write: address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_got  = 1'b1;
      next_r.aw_addr = obl_word_addr(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_got  = 1'b1;
      next_r.w_data = s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      next_r.aw_got = 1'b0;
      next_r.w_got  = 1'b0;
      next_r.bvalid = 1'b1;
      if (r.aw_addr == `OBL_REG_CTRL) begin
        next_r.bresp = `OBL_RESP_OKAY;
        // request held but has no effect while locked
        next_r.stop_req = r.w_data[`OBL_CTRL_STOP_BIT];
      end else begin
        // option copies are read only
        next_r.bresp = `OBL_RESP_SLVERR;
      end
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end

    // axi read
    if (s_axi_arvalid && s_axi_arready) begin
      ra            = s_axi_araddr;
      rd_word       = obl_read(r, ra, rd_ok);
      next_r.rvalid = 1'b1;
      next_r.rdata  = rd_word;
      next_r.rresp  = rd_ok ? `OBL_RESP_OKAY : `OBL_RESP_SLVERR;
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
  end

  // =========================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r       <= '0;
      r.phase <= obl_pkg::obl_idle_s;
    end else begin
      r <= next_r;
    end
  end

  // =========================================================
  // outputs
  assign flash_rd_req  = r.rd_req;
  assign flash_rd_addr = r.rd_addr;
  // cpu held until options are loaded
  assign cpu_release   = done;

  assign internal_osc_run = !(done && !lock && r.stop_req);
  assign wdt_clk_enable = internal_osc_run && !(halt_or_stop && !lock);
  assign h1_clk_enable  = h1_on_internal_osc && internal_osc_run;

  // =========================================================
  // debug control
  // 00 disables, 01 flagged and treated as disabled
  assign debug_setting_bad   = done && obl_dbg_bad(dbg);
  assign debug_enable        = done && obl_dbg_on(dbg);
  assign debug_erase_on_fail = done && obl_dbg_wipe(dbg);

  // =========================================================
  // register bus handshakes
  assign s_axi_awready = !r.aw_got && aresetn;
  assign s_axi_wready  = !r.w_got && aresetn;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = !r.rvalid && aresetn;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;

endmodule

// File: dv/obl_flash_model.sv
`timescale 1ns/1ps
module obl_flash_model (
  input  wire logic        aclk,
  input  wire logic        req,
  input  wire logic [15:0] addr,
  input  wire logic        slow,
  output logic             valid,
  output logic [7:0]       data
);
  // slots 0-4 primary copy, 5-9 alternate copy, loaded by the bench
  logic [7:0] mem [0:9];
  logic [1:0] wait_cnt;
  initial begin
    valid = 1'b0;
    data = 8'h5a;
    wait_cnt = 2'h0;
  end
  // =====================================
  // byte answer, slow mode stalls three cycles
  always @(posedge aclk) begin
    if (valid) begin
      valid <= 1'b0;
      // released bus must not look like the last byte
      data <= ~data;
    end else if (req && (!slow || wait_cnt == 2'h3)) begin
      valid <= 1'b1;
      data <= mem[(addr[12] ? 5 : 0) + addr[2:0]];
      wait_cnt <= 2'h0;
    end else if (req) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

// File: dv/obl_asserts.sv
`timescale 1ns/1ps
module obl_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        boot_swap,
  input wire logic        flash_rd_req,
  input wire logic [15:0] flash_rd_addr,
  input wire logic        flash_rd_valid,
  input wire logic        cpu_release,
  input wire logic        internal_osc_run,
  input wire logic        h1_on_internal_osc,
  input wire logic        h1_clk_enable,
  input wire logic        debug_enable,
  input wire logic        debug_erase_on_fail,
  input wire logic        debug_setting_bad,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // =====================================
  // flash fetch
  area_range_a: assert property (
    flash_rd_req |-> flash_rd_addr[11:0] inside {[12'h080:12'h084]})
    else $error("flash read outside option area");
  swap_range_a: assert property (
    flash_rd_req |-> flash_rd_addr[15:12] == {3'h0, boot_swap})
    else $error("flash range does not follow boot swap");
  req_hold_a: assert property (
    flash_rd_req && !flash_rd_valid |=> flash_rd_req && $stable(flash_rd_addr))
    else $error("flash request dropped before answer");
  fetch_gap_a: assert property (
    flash_rd_req && flash_rd_valid |=> !flash_rd_req)
    else $error("no idle cycle between fetches");
  // =====================================
  // applied configuration and write response hold
  load_first_a: assert property (
    !cpu_release |-> internal_osc_run && !debug_enable && !debug_erase_on_fail)
    else $error("settings applied before load");
  release_hold_a: assert property (
    cpu_release ##1 cpu_release |-> $stable({debug_enable, debug_erase_on_fail}))
    else $error("loaded debug setting changed");
  bad_setting_a: assert property (
    debug_setting_bad |-> !debug_enable && !debug_erase_on_fail)
    else $error("prohibited setting enabled debug");
  h1_clock_a: assert property (
    h1_clk_enable == (h1_on_internal_osc && internal_osc_run))
    else $error("timer clock gating wrong");
  resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
endmodule
bind obl_option_byte_loader obl_asserts chk (.*);

// File: dv/obl_option_byte_loader_test.sv
`timescale 1ns/1ps
`include "obl_params.svh"
module obl_option_byte_loader_test;
  logic aclk, aresetn, boot_swap, flash_rd_req, flash_rd_valid, cpu_release;
  logic internal_osc_run, halt_or_stop, h1_on_internal_osc, wdt_clk_enable;
  logic h1_clk_enable, debug_enable, debug_erase_on_fail, debug_setting_bad;
  logic [15:0] flash_rd_addr;
  logic [7:0]  flash_rd_data, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic slow;
  int   fails, compares, cyc;
  obl_option_byte_loader uut (.*);
  obl_flash_model fl (.aclk(aclk), .req(flash_rd_req), .addr(flash_rd_addr),
    .slow(slow), .valid(flash_rd_valid), .data(flash_rd_data));
  always #50 aclk = ~aclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      wrap_up;
    end
  end
  // =====================================
  // bus cycles, ready sampled mid-cycle so the edge decides
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ha, hw, hb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!hb);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ha, hr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
    end while (!hr);
    s_axi_rready <= 1'b0;
  endtask
  task automatic load(input logic sw, input logic [7:0] ob,
                      input logic [7:0] db, input logic sl);
    for (int i = 0; i < 10; i++) fl.mem[i] = 8'h00;
    fl.mem[0] = ob;
    fl.mem[5] = ob;
    fl.mem[4] = db;
    fl.mem[9] = db;
    aresetn <= 1'b0;
    boot_swap <= sw;
    slow <= sl;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    while (!cpu_release) @(posedge aclk);
  endtask
  task automatic t_debug;
    logic [31:0] d;
    logic [1:0]  r;
    for (int k = 0; k < 4; k++) begin
      load(k[0], 8'h01, {6'h00, k[1:0]}, k[1]);
      chk(debug_enable, k[1]);
      chk(debug_erase_on_fail, k == 3);
      chk(debug_setting_bad, k == 1);
      rd(`OBL_REG_DBG_OPT, d, r);
      chk(d, {30'h0, k[1:0]});
      rd(`OBL_REG_STATUS, d, r);
      chk(d[5], k[0]);
    end
    $display("debug modes done");
  endtask
  task automatic t_osc;
    logic [31:0] d;
    logic [1:0]  r;
    for (int k = 0; k < 2; k++) begin
      load(1'b0, k[7:0], 8'h00, 1'b0);
      @(posedge aclk);
      halt_or_stop <= 1'b1;
      h1_on_internal_osc <= 1'b1;
      @(negedge aclk);
      chk(wdt_clk_enable, k[0]);
      chk(h1_clk_enable, 1'b1);
      wr(`OBL_REG_CTRL, 32'h1, r);
      @(negedge aclk);
      chk(internal_osc_run, k[0]);
      chk(h1_clk_enable, k[0]);
      wr(`OBL_REG_OSC_OPT, 32'h1, r);
      chk(r, `OBL_RESP_SLVERR);
      rd(`OBL_REG_OSC_OPT, d, r);
      chk(d, k);
      rd(8'h40, d, r);
      chk(r, `OBL_RESP_SLVERR);
      halt_or_stop <= 1'b0;
    end
    $display("oscillator lock done");
  endtask
  initial begin
    {aclk, aresetn, boot_swap, halt_or_stop, h1_on_internal_osc, slow} = 6'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {fails, compares, cyc} = 0;
    t_debug;
    t_osc;
    wrap_up;
  end
endmodule
